// ==== hw/asc_pkg.sv ====
/*
 * Package for the single- and scan-mode converter sequencer: register offsets,
 * field positions, reset values and sizing constants.
 * Assumes a 32-bit APB with word-aligned byte addresses.
 */
package asc_pkg;
    // Converter geometry
    localparam int RES_BITS     = 10;
    localparam int NUM_CH       = 8;
    localparam int CH_BITS      = 3;
    localparam int SAMPLE_CYC   = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CSR      = 8'h00;
    localparam logic [7:0] OFS_DATA0    = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h44;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h48;

    // converter_control_status_reg fields
    localparam int CSR_START    = 0;
    localparam int CSR_SCAN     = 1;
    localparam int CSR_CH_LO    = 2;
    localparam int CSR_TMR_EN   = 5;
    localparam int CSR_EXT_EN   = 6;
    localparam int CSR_BUSY     = 7;

    // Interrupt status/clear/enable field
    localparam int IRQ_END      = 0;

    // Reset values and the mid-scale first trial code
    localparam logic [7:0]          CSR_RST   = 8'h00;
    localparam logic [RES_BITS-1:0] DATA_RST  = 10'h000;
    localparam logic [RES_BITS-1:0] DAC_MID   = 10'h200;

    typedef enum logic [1:0] {
        SAR_IDLE,
        SAR_SAMPLE,
        SAR_CONV
    } asc_sar_state_type;
endpackage

// ==== hw/asc_sar_core.sv ====
/*
 * Successive-approximation engine: sample phase, then one trial bit per
 * clock from the MSB down. Assumes an external DAC and comparator where
 * cmp_in is high when the held input is at or above dac_code.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_sar_core
    import asc_pkg::*;
#(
    parameter int SAMPLE_LEN = SAMPLE_CYC
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                start,
    input  wire logic                abort,
    input  wire logic                cmp_in,
    output logic                     busy,
    output logic                     done,
    output logic                     hold,
    output logic [RES_BITS-1:0]      dac_code,
    output logic [RES_BITS-1:0]      result
);
    localparam int LAT = SAMPLE_LEN + 11;

    asc_sar_state_type         state_q;
    logic [3:0]                cnt_q;
    logic [RES_BITS-1:0]       dac_q;
    logic [RES_BITS-1:0]       res_q;
    logic                      done_q;

    // Keep or drop the bit under trial, then arm the next lower bit
    wire [RES_BITS-1:0] trial_bit = RES_BITS'(1) << cnt_q;
    wire [RES_BITS-1:0] kept      = cmp_in ? dac_q : (dac_q & ~trial_bit);
    wire [RES_BITS-1:0] next_try  = kept | (trial_bit >> 1);

    // Sequencer; abort returns to idle with no result
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SAR_IDLE;
            cnt_q   <= 4'h0;
            dac_q   <= DATA_RST;
            res_q   <= DATA_RST;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                SAR_IDLE: begin
                    if (start && !abort) begin
                        state_q <= SAR_SAMPLE;
                        cnt_q   <= 4'(SAMPLE_LEN - 1);
                    end
                end
                SAR_SAMPLE: begin
                    if (abort) begin
                        state_q <= SAR_IDLE;
                    end else if (cnt_q == 4'h0) begin
                        state_q <= SAR_CONV;
                        cnt_q   <= 4'(RES_BITS - 1);
                        dac_q   <= DAC_MID;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                SAR_CONV: begin
                    if (abort) begin
                        state_q <= SAR_IDLE;
                    end else if (cnt_q == 4'h0) begin
                        res_q   <= kept;
                        done_q  <= 1'b1;
                        state_q <= SAR_IDLE;
                    end else begin
                        dac_q <= next_try;
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= SAR_IDLE;
            endcase
        end
    end

    assign busy     = (state_q != SAR_IDLE);
    assign done     = done_q;
    assign hold     = (state_q == SAR_CONV);
    assign dac_code = dac_q;
    assign result   = res_q;

    // Ten trials after the sample phase, never more
    a_sar_latency: assert property (@(posedge clk) disable iff (!arst_n || abort)
        (start && state_q == SAR_IDLE) |-> ##LAT done_q)
        else $error("conversion did not end after sample plus ten trials");
endmodule // asc_sar_core
`default_nettype wire

// ==== hw/asc_ctrl.sv ====
/*
 * Single- and scan-mode converter control: APB register file, start bit with its
 * three sources, per-channel result registers, end flag and interrupt.
 * Assumes APB master timing and a synchronous timer and external trigger.
 */
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl
    import asc_pkg::*;
#(
    parameter int SAMPLE_LEN = SAMPLE_CYC
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                timer_trig,
    input  wire logic                ext_trig,
    input  wire logic                cmp_in,
    output logic [RES_BITS-1:0]      dac_code,
    output logic [CH_BITS-1:0]       chan_sel,
    output logic                     sample_hold,
    output logic                     conversion_end_interrupt
);
    // Data register index from a byte address inside the data window
    function automatic logic [CH_BITS-1:0] data_idx(input logic [7:0] a);
        data_idx = CH_BITS'((a - OFS_DATA0) >> 2);
    endfunction

    logic                      start_q;
    logic                      scan_q;
    logic [CH_BITS-1:0]        ch_q;
    logic                      tmr_en_q;
    logic                      ext_en_q;
    logic                      flag_q;
    logic                      irq_en_q;
    logic                      irq_q;
    logic                      launch_q;
    logic [CH_BITS-1:0]        conv_ch_q;
    logic [CH_BITS-1:0]        scan_ch_q;
    logic [RES_BITS-1:0]       data_q [NUM_CH];
    logic                      pready_q;
    logic                      pslverr_q;
    logic [31:0]               prdata_q;
    logic                      hold_q;
    logic                      core_busy;
    logic                      core_done;
    logic                      core_hold;
    logic [RES_BITS-1:0]       core_dac;
    logic [RES_BITS-1:0]       core_res;

    // APB decode; the access edge is the one where pready is seen high
    wire       acc      = psel && penable && pready_q;
    wire       wr       = acc && pwrite;
    // Setup cycle of a transfer, shared by the response logic and checks
    wire       setup    = psel && !penable;
    wire       hit_csr  = (paddr == OFS_CSR);
    wire       hit_data = (paddr >= OFS_DATA0) && (paddr < OFS_DATA0 + 8'(4 * NUM_CH))
                          && (paddr[1:0] == 2'b00);
    wire       hit_stat = (paddr == OFS_IRQ_STAT);
    wire       hit_clr  = (paddr == OFS_IRQ_CLR);
    wire       hit_en   = (paddr == OFS_IRQ_EN);
    wire       mapped   = hit_csr || hit_data || hit_stat || hit_clr || hit_en;
    wire       wr_csr   = wr && hit_csr;
    wire       wr_clr   = wr && hit_clr && pwdata[IRQ_END];
    wire       wr_en    = wr && hit_en;

    // Start sources; a trigger while a conversion runs is absorbed
    wire       hw_trig   = (timer_trig && tmr_en_q) || (ext_trig && ext_en_q);
    wire       start_set = (wr_csr && pwdata[CSR_START]) || hw_trig;
    wire       start_clr = (wr_csr && !pwdata[CSR_START])
                           || (core_done && !scan_q);
    // Set wins over any clear arriving in the same cycle
    wire       start_d   = start_set || (start_q && !start_clr);
    wire       abort     = start_q && !start_d && core_busy;
    wire       launch    = start_q && start_d && !core_busy && !launch_q && !core_done;
    wire [CH_BITS-1:0] launch_ch = scan_q ? scan_ch_q : ch_q;

    // End flag and interrupt; an end event beats a clear in the same cycle
    wire       flag_d    = core_done || (flag_q && !wr_clr);
    wire       irq_en_d  = wr_en ? pwdata[IRQ_END] : irq_en_q;
    wire       irq_d     = flag_d && irq_en_d;

    // Read mux
    wire [7:0] csr_view  = {core_busy, ext_en_q, tmr_en_q, ch_q, scan_q, start_q};
    wire [31:0] rd_mux   = hit_csr  ? {24'h00_0000, csr_view} :
                           hit_data ? {22'h00_0000, data_q[data_idx(paddr)]} :
                           hit_stat ? {31'h0000_0000, flag_q} :
                           hit_en   ? {31'h0000_0000, irq_en_q} :
                                      32'h0000_0000;

    // Bus response: no wait states, data and error ready with pready
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup && !pready_q;
            pslverr_q <= setup && !mapped;
            prdata_q  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Control/status fields. Mode and channel are taken as written;
    // software is expected to stop the converter first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_q  <= CSR_RST[CSR_START];
            scan_q   <= CSR_RST[CSR_SCAN];
            ch_q     <= CSR_RST[CSR_CH_LO +: CH_BITS];
            tmr_en_q <= CSR_RST[CSR_TMR_EN];
            ext_en_q <= CSR_RST[CSR_EXT_EN];
        end else begin
            start_q <= start_d;
            if (wr_csr) begin
                scan_q   <= pwdata[CSR_SCAN];
                ch_q     <= pwdata[CSR_CH_LO +: CH_BITS];
                tmr_en_q <= pwdata[CSR_TMR_EN];
                ext_en_q <= pwdata[CSR_EXT_EN];
            end
        end
    end

    // Channel latched at launch so a late write cannot misroute a result
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            launch_q  <= 1'b0;
            conv_ch_q <= '0;
            scan_ch_q <= '0;
        end else begin
            launch_q <= launch;
            if (launch) begin
                conv_ch_q <= launch_ch;
            end
            if (!start_q) begin
                scan_ch_q <= '0;
            end else if (core_done && scan_q) begin
                scan_ch_q <= (scan_ch_q >= ch_q) ? '0 : scan_ch_q + 1'b1;
            end
        end
    end

    // Per-channel result registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                data_q[i] <= DATA_RST;
            end
        end else if (core_done) begin
            data_q[conv_ch_q] <= core_res;
        end
    end

    // Flag, enable and interrupt line
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            flag_q   <= flag_d;
            irq_en_q <= irq_en_d;
            irq_q    <= irq_d;
        end
    end

    // Hold pin registered for a clean edge. The trial code is not: the
    // comparator must judge the code under trial, not the one before it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= core_hold;
        end
    end

    asc_sar_core #(
        .SAMPLE_LEN (SAMPLE_LEN)
    ) u_core (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (launch),
        .abort    (abort),
        .cmp_in   (cmp_in),
        .busy     (core_busy),
        .done     (core_done),
        .hold     (core_hold),
        .dac_code (core_dac),
        .result   (core_res)
    );

    assign prdata                   = prdata_q;
    assign pready                   = pready_q;
    assign pslverr                  = pslverr_q;
    assign dac_code                 = core_dac;
    assign chan_sel                 = conv_ch_q;
    assign sample_hold              = hold_q;
    assign conversion_end_interrupt = irq_q;

    // Checks
    a_apb_wait_one: assert property (@(posedge clk) disable iff (!arst_n)
        (psel && !penable) |=> pready_q)
        else $error("pready not given one cycle after setup");
    a_start_launches: assert property (@(posedge clk) disable iff (!arst_n)
        ($rose(start_q) && !core_busy && start_d) |-> ##[0:2] core_busy)
        else $error("start bit did not begin a conversion");
    a_result_stored: assert property (@(posedge clk) disable iff (!arst_n)
        core_done |=> (data_q[$past(conv_ch_q)] == $past(core_res)))
        else $error("result not written to the converted channel");
    a_end_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
        core_done |=> flag_q)
        else $error("end flag not set on completion");
    a_irq_follows: assert property (@(posedge clk) disable iff (!arst_n)
        conversion_end_interrupt == (flag_q && irq_en_q))
        else $error("interrupt does not match flag and enable");
    a_start_clears: assert property (@(posedge clk) disable iff (!arst_n)
        (core_done && !scan_q && !start_set) |=> !start_q)
        else $error("start bit not cleared at end of single conversion");
    a_start_held: assert property (@(posedge clk) disable iff (!arst_n)
        (core_busy && !launch_q && !core_done) |-> start_q)
        else $error("start bit low while converting");
    a_single_once: assert property (@(posedge clk) disable iff (!arst_n)
        (core_done && !scan_q && !start_set) |=> !core_busy [*2])
        else $error("single mode converted again without a start");

    // Bus response shape
    a_ready_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        pready_q |=> !pready_q)
        else $error("pready held for more than one cycle");
    a_ready_after_setup: assert property (@(posedge clk) disable iff (!arst_n)
        pready_q |-> $past(setup))
        else $error("pready without a setup cycle before it");
    a_err_with_ready: assert property (@(posedge clk) disable iff (!arst_n)
        pslverr_q |-> pready_q)
        else $error("pslverr outside the access cycle");
    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!arst_n)
        !pready_q |-> (prdata_q == 32'h0000_0000))
        else $error("read data not zero outside the access cycle");

    // Start bit sources and launch
    a_start_by_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_csr && pwdata[CSR_START]) |=> start_q)
        else $error("software write did not set the start bit");
    a_start_by_timer: assert property (@(posedge clk) disable iff (!arst_n)
        (timer_trig && tmr_en_q) |=> start_q)
        else $error("timer trigger did not set the start bit");
    a_start_by_pin: assert property (@(posedge clk) disable iff (!arst_n)
        (ext_trig && ext_en_q) |=> start_q)
        else $error("external trigger did not set the start bit");
    a_start_no_source: assert property (@(posedge clk) disable iff (!arst_n)
        (!start_q && !start_set) |=> !start_q)
        else $error("start bit set with no source");
    a_launch_busy: assert property (@(posedge clk) disable iff (!arst_n)
        launch |=> core_busy)
        else $error("launch did not start the engine");
    a_abort_idle: assert property (@(posedge clk) disable iff (!arst_n)
        abort |=> (!core_busy && !start_q))
        else $error("abort did not stop the engine");

    // Results, flag and interrupt
    a_abort_no_end: assert property (@(posedge clk) disable iff (!arst_n)
        abort |=> !core_done)
        else $error("aborted conversion reported an end");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        (flag_q && !wr_clr) |=> flag_q)
        else $error("end flag dropped without a clear");
    a_flag_cleared: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_clr && !core_done) |=> !flag_q)
        else $error("end flag not cleared by the clear register");
    a_irq_on_done: assert property (@(posedge clk) disable iff (!arst_n)
        (core_done && irq_en_d) |=> conversion_end_interrupt)
        else $error("enabled completion raised no interrupt");
    a_chan_fixed: assert property (@(posedge clk) disable iff (!arst_n)
        (core_busy && !core_done) |=> $stable(conv_ch_q))
        else $error("channel changed during a conversion");

    // Engine-facing pins
    a_first_trial_mid: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(core_hold) |-> (core_dac == DAC_MID))
        else $error("first trial code is not mid-scale");
    a_hold_follows: assert property (@(posedge clk) disable iff (!arst_n)
        sample_hold == $past(core_hold))
        else $error("hold pin does not follow the trial phase");
    a_done_after_busy: assert property (@(posedge clk) disable iff (!arst_n)
        core_done |-> $past(core_busy))
        else $error("end reported without a conversion");

    c_single_done: cover property (@(posedge clk) disable iff (!arst_n)
        core_done && !scan_q);
    c_scan_wrap: cover property (@(posedge clk) disable iff (!arst_n)
        core_done && scan_q && (scan_ch_q == ch_q));
    c_irq_rise: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(conversion_end_interrupt));
    c_abort: cover property (@(posedge clk) disable iff (!arst_n) abort);
endmodule // asc_ctrl
`default_nettype wire

// ==== bench/asc_front_model.sv ====
/*
 * Far-side model for the converter control block: timer and external
 * trigger sources plus an ideal comparator on the held analog level.
 * Assumes the bench commands each trigger pulse and sets the level.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_front_model
    import asc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                fire_tmr,
    input  wire logic                fire_ext,
    input  wire logic [RES_BITS-1:0] vin,
    input  wire logic [RES_BITS-1:0] dac_code,
    output logic                     timer_trig,
    output logic                     ext_trig,
    output logic                     cmp_in
);
    // Triggers idle low, one-cycle pulses launched just after an edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_trig <= 1'b0;
            ext_trig   <= 1'b0;
        end else begin
            timer_trig <= fire_tmr;
            ext_trig   <= fire_ext;
        end
    end

    // Ideal comparator, no offset modelled
    assign cmp_in = (vin >= dac_code);
endmodule // asc_front_model
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench for the converter control block: APB master,
 * table of single conversions, then reset, masking and abort cases.
 * Assumes a 20 MHz clock and a shortened sample phase.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import asc_pkg::*;
    typedef struct {
        logic [CH_BITS-1:0]  ch;
        logic [RES_BITS-1:0] vin;
        int                  src;
        logic [31:0]         exp;
    } asc_row_type;
    logic                clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic                timer_trig, ext_trig, cmp_in, sample_hold, irq;
    logic                fire_tmr, fire_ext, err, seen_busy;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [RES_BITS-1:0] dac_code, vin;
    logic [CH_BITS-1:0]  chan_sel;
    int                  num_errors, total_checks, hold_base;
    int                  hold_cycles = 0;
    // Sources: 0 software, 1 timer, 2 external pin; boundary codes included
    asc_row_type rows [5] = '{
        '{3'h0, 10'h000, 0, 32'h0000_0000},
        '{3'h7, 10'h3ff, 1, 32'h0000_03ff},
        '{3'h3, 10'h155, 2, 32'h0000_0155},
        '{3'h5, 10'h2aa, 0, 32'h0000_02aa},
        '{3'h2, 10'h200, 1, 32'h0000_0200}
    };

    asc_ctrl #(.SAMPLE_LEN(2)) i_dut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_trig(timer_trig),
        .ext_trig(ext_trig), .cmp_in(cmp_in), .dac_code(dac_code),
        .chan_sel(chan_sel), .sample_hold(sample_hold),
        .conversion_end_interrupt(irq)
    );
    asc_front_model i_front (
        .clk(clk), .arst_n(arst_n), .fire_tmr(fire_tmr), .fire_ext(fire_ext),
        .vin(vin), .dac_code(dac_code), .timer_trig(timer_trig),
        .ext_trig(ext_trig), .cmp_in(cmp_in)
    );

    // 50 ns period
    always #25 clk = ~clk;

    // Cycles with the input held, one per trial bit
    always @(posedge clk) begin
        if (sample_hold === 1'b1) hold_cycles <= hold_cycles + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer; an edge passes first so strobes never double-assign
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Launch from one source, then poll the start bit until it self-clears
    task automatic conv(input logic [CH_BITS-1:0] ch, input int src);
        logic [31:0] v;
        int          n;
        v = 32'(ch) << CSR_CH_LO;
        v[CSR_START]  = (src == 0);
        v[CSR_TMR_EN] = (src == 1);
        v[CSR_EXT_EN] = (src == 2);
        apb(1'b1, OFS_CSR, v);
        fire_tmr <= (src == 1);
        fire_ext <= (src == 2);
        @(posedge clk);
        fire_tmr <= 1'b0;
        fire_ext <= 1'b0;
        for (n = 0; n < 40; n++) begin
            apb(1'b0, OFS_CSR, 32'h0000_0000);
            if (n == 0) seen_busy = rd[CSR_START];
            if (rd[CSR_START] === 1'b0) break;
        end
        if (n == 40) begin
            num_errors++;
            results();
        end
        chk(32'(seen_busy), 32'h0000_0001);
    endtask

    initial begin
        clk = 1'b0; arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; vin = 10'h000;
        fire_tmr = 1'b0; fire_ext = 1'b0; num_errors = 0; total_checks = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        // Reset state of control, flag and interrupt line
        chk(32'(irq), 32'h0000_0000);
        apb(1'b0, OFS_CSR, 32'h0000_0000);
        chk(rd, 32'(CSR_RST));
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        // Table of single conversions; channel changes ride with the start
        foreach (rows[i]) begin
            vin <= rows[i].vin;
            hold_base = hold_cycles;
            conv(rows[i].ch, rows[i].src);
            chk(32'(hold_cycles - hold_base), 32'(RES_BITS));
            apb(1'b0, OFS_DATA0 + 8'(4 * rows[i].ch), 32'h0000_0000);
            chk(rd, rows[i].exp);
            chk(32'(chan_sel), 32'(rows[i].ch));
            apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            chk(32'(irq), 32'h0000_0001);
            apb(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
            apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
            chk(32'(irq), 32'h0000_0000);
        end
        // Unconverted channel untouched, read-only data ignores writes
        apb(1'b1, OFS_DATA0 + 8'h04, 32'h0000_03ff);
        apb(1'b0, OFS_DATA0 + 8'h04, 32'h0000_0000);
        chk(rd, 32'(DATA_RST));
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        // Masked completion: flag without request, then enable raises it
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
        vin <= 10'h0f0;
        conv(3'h4, 0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_CLR, 32'h0000_0000);
        chk({rd[30:0], irq}, 32'h0000_0001);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
        // Single mode: no further conversion without a new start
        repeat (40) @(posedge clk);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk({rd[30:0], irq}, 32'h0000_0000);
        // Start cleared mid-conversion: no result, no flag
        vin <= 10'h123;
        apb(1'b1, OFS_CSR, 32'h0000_0019);
        apb(1'b1, OFS_CSR, 32'h0000_0018);
        repeat (40) @(posedge clk);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, OFS_DATA0 + 8'h18, 32'h0000_0000);
        chk(rd, 32'(DATA_RST));
        // Scan over channels 0 and 1, stopped by clearing start
        vin <= 10'h2c1;
        apb(1'b1, OFS_CSR, 32'h0000_0007);
        repeat (60) @(posedge clk);
        apb(1'b1, OFS_CSR, 32'h0000_0006);
        apb(1'b0, OFS_DATA0, 32'h0000_0000);
        chk(rd, 32'h0000_02c1);
        apb(1'b0, OFS_DATA0 + 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_02c1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
        apb(1'b1, OFS_CSR, 32'h0000_0000);
        // Reset on the edge that writes the start bit returns everything to idle
        apb(1'b1, OFS_CSR, 32'h0000_0001);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, OFS_CSR, 32'h0000_0000);
        chk({rd[30:0], irq}, 32'h0000_0000);
        results();
    end
endmodule // tb
`default_nettype wire
